// ### pkg/lhcd_pkg.sv
// constants and types shared by the host command decoder
package lhcd_pkg;
   // clock and execution times
   localparam int CLK_NS = 40;
   localparam int INSTR_NS = 37000;
   localparam int DATA_NS = 43000;
   localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int DATA_CYC = (DATA_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] INSTR_CNT = CNT_W'(INSTR_CYC);
   localparam logic [CNT_W-1:0] DATA_CNT = CNT_W'(DATA_CYC);
   // widths and sizes
   localparam int AC_W = 7;
   localparam int CODE_W = 10;
   localparam int PIN_W = 12;
   // serial frame: register pick bit, then eight data bits msb first
   localparam logic [3:0] SER_LAST = 4'h8;
   // character ram line layout
   localparam logic [5:0] LINE2_LAST = 6'h27;
   localparam logic [4:0] LINE4_LAST = 5'h13;
   // function set field positions
   localparam int FS_IF_POS = 4;
   localparam int FS_EXT_POS = 2;
   localparam int FS_SEL_POS = 1;
   localparam int FS_REV_POS = 0;
   // reset values
   localparam logic [AC_W-1:0] RST_AC = 7'h00;
   localparam logic [1:0] RST_BANK = 2'h0;
   localparam logic [3:0] RST_LINE_EN = 4'h0;
   localparam logic [6:0] RST_SPI_LEN = 7'h00;
   localparam logic RST_BUS8 = 1'b1;
   localparam logic RST_DIR_UP = 1'b1;
   // bank that holds the user font
   localparam logic [1:0] BANK_USER = 2'h0;
   typedef enum logic [1:0] {
      TGT_CHAR = 2'b00,
      TGT_FONT = 2'b01,
      TGT_ICON = 2'b10
   } lhcd_tgt_e;
endpackage

// ### design/lhcd_host_if.sv
// host command decoder of the character display controller
//
// Summary of operation
// - plain shift moves display or cursor, 37us
// - extended shift with selector 1 loads line enables
// - extended shift with selector 0 picks font bank
// - function set loads bus width and extension bit
// - plain function set stores line-shift/bank selector
// - plain function set bit0 inverts whole display
// - extended function set, bit0 zero, sets font blink
// - plain 01xxxxxx loads user font address
// - extended 01xxxxxx loads icon address, four bits
// - plain 1xxxxxxx loads character ram address
// - extended 1xxxxxxx stores serial frame length
// - status read gives busy and address counter
// - data access hits targeted ram within 43us
// - bus kind pin picks serial or parallel
// - latch refetches after read, commits after write
// - command latch can never be read back
// - register pick from pin or serial bit
// - no instruction taken while busy
// - character ram holds bank bits plus data
// - user font reachable only from bank zero
// - two-line map 00-27h and 40-67h
// - address counter steps after each data access
// - four-line map 00-13h,20-33h,40-53h,60-73h
`timescale 1ns/10ps
module lhcd_host_if (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic bus_kind_select_i,
   input wire logic register_pick_i,
   input wire logic rw_i,
   input wire logic e_i,
   input wire logic [7:0] db_i,
   output logic [7:0] db_o,
   output logic [7:0] db_oe_o,
   input wire logic [lhcd_pkg::AC_W-1:0] disp_addr_i,
   output logic [lhcd_pkg::CODE_W-1:0] disp_code_o,
   output logic disp_user_o,
   output logic shift_pulse_o,
   output logic shift_display_o,
   output logic shift_right_o,
   output logic [3:0] line_shift_en_o,
   output logic [1:0] rom_bank_sel_o,
   output logic line_shift_or_bank_o,
   output logic invert_all_o,
   output logic font_blink_en_o,
   output logic four_line_o,
   output logic ext_instr_bit_o,
   output logic bus_8bit_o,
   output logic [6:0] spi_frame_len_o
);
   import lhcd_pkg::*;

   // character ram address step with line wrap
   function automatic logic [AC_W-1:0] step_dd(input logic [AC_W-1:0] a, input logic up,
                                               input logic four);
      logic [AC_W-1:0] r;
      if (four) begin
         if (up) r = (a[4:0] == LINE4_LAST) ? {2'(a[6:5] + 2'd1), 5'h00} : 7'(a + 7'd1);
         else r = (a[4:0] == 5'h00) ? {2'(a[6:5] - 2'd1), LINE4_LAST} : 7'(a - 7'd1);
      end else begin
         if (up) r = (a[5:0] == LINE2_LAST) ? {~a[6], 6'h00} : 7'(a + 7'd1);
         else r = (a[5:0] == 6'h00) ? {~a[6], LINE2_LAST} : 7'(a - 7'd1);
      end
      return r;
   endfunction

   // address is inside a displayed line
   function automatic logic dd_ok(input logic [AC_W-1:0] a, input logic four);
      return four ? (a[4:0] <= LINE4_LAST) : (a[5:0] <= LINE2_LAST);
   endfunction

   // pin synchroniser: s1 feeds only s2; a bit settles once s2 and s3 agree
   logic [PIN_W-1:0] s1, s2, s3, st, st_q;
   wire [PIN_W-1:0] pin_raw = {bus_kind_select_i, register_pick_i, rw_i, e_i, db_i};
   wire [PIN_W-1:0] s_diff = s2 ^ s3;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         st <= '0;
         st_q <= '0;
      end else begin
         s1 <= pin_raw;
         s2 <= s1;
         s3 <= s2;
         st <= (s3 & ~s_diff) | (st & s_diff);
         st_q <= st;
      end
   end

   // settled pins; serial mode reuses db5..db7 as select, clock and data
   wire bus_kind_select = st[11];
   wire rs_p = st[10];
   wire rw_p = st[9];
   wire e_p = st[8];
   wire [7:0] dbv = st[7:0];
   wire e_fall = bus_kind_select & st_q[8] & ~e_p;
   wire csb = st[5];
   wire sclk_rise = st[6] & ~st_q[6];
   wire sid = st[7];

   // serial frame shifter; its bit count clears while deselected, the shift register keeps its bits
   logic [3:0] ser_cnt;
   logic [7:0] ser_sh;
   wire ser_on = ~bus_kind_select & ~csb;
   wire ser_done = ser_on & sclk_rise & (ser_cnt == SER_LAST);
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ser_cnt <= 4'h0;
         ser_sh <= 8'h00;
      end else if (!ser_on) begin
         ser_cnt <= 4'h0;
      end else if (sclk_rise) begin
         ser_sh <= {ser_sh[6:0], sid};
         ser_cnt <= ser_done ? 4'h0 : 4'(ser_cnt + 4'h1);
      end
   end

   // 4-bit mode pairs two strobes, high nibble first
   logic nib_ph;
   logic [3:0] nib_hi;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         nib_ph <= 1'b0;
         nib_hi <= 4'h0;
      end else if (e_fall && !bus_8bit_o) begin
         nib_ph <= ~nib_ph;
         if (!nib_ph) nib_hi <= dbv[7:4];
      end
   end

   // one access event from either link
   wire par_done = e_fall & (bus_8bit_o | nib_ph);
   wire ev_valid = par_done | ser_done;
   wire ev_rs = bus_kind_select ? rs_p : ser_sh[7];
   wire ev_rw = bus_kind_select & rw_p;
   wire [7:0] ev_byte = bus_kind_select ? (bus_8bit_o ? dbv : {nib_hi, dbv[7:4]}) : {ser_sh[6:0], sid};

   // busy counter and acceptance; a busy device drops the access silently
   logic [CNT_W-1:0] busy_cnt;
   wire busy_flag = (busy_cnt != '0);
   wire ins_go = ev_valid & ~ev_rs & ~ev_rw & ~busy_flag;
   wire dat_wr = ev_valid & ev_rs & ~ev_rw & ~busy_flag;
   wire dat_rd = ev_valid & ev_rs & ev_rw & ~busy_flag;

   // opcode decode; the stored extension bit picks each overlapping pair
   wire re = ext_instr_bit_o;
   wire op_entry = (ev_byte[7:2] == 6'b000001) & ~re;
   wire op_extfs = (ev_byte[7:2] == 6'b000010) & re;
   wire op_shift = (ev_byte[7:4] == 4'b0001);
   wire op_fs = (ev_byte[7:5] == 3'b001);
   wire op_font = (ev_byte[7:6] == 2'b01);
   wire op_dd = ev_byte[7];
   wire op_addr = ins_go & (op_font | (op_dd & ~re));

   // ram state and the transfer latch
   logic [CODE_W-1:0] char_code_ram [128];
   logic [7:0] user_font_ram [64];
   logic [7:0] icon_ram [16];
   lhcd_tgt_e tgt;
   logic [AC_W-1:0] addr_counter;
   logic [7:0] ram_transfer_latch;
   logic dir_up, fetch_q;
   wire [7:0] cur_rd = (tgt == TGT_FONT) ? user_font_ram[addr_counter[5:0]] :
                       (tgt == TGT_ICON) ? icon_ram[addr_counter[3:0]] :
                       char_code_ram[addr_counter][7:0];
   wire [AC_W-1:0] ac_step = (tgt == TGT_FONT) ? {1'b0, 6'(addr_counter[5:0] + (dir_up ? 6'd1 : 6'h3f))} :
                             (tgt == TGT_ICON) ? {3'b0, 4'(addr_counter[3:0] + (dir_up ? 4'd1 : 4'hf))} :
                             step_dd(addr_counter, dir_up, four_line_o);
   wire dd_wr_ok = dd_ok(addr_counter, four_line_o);

   // busy time per kind of access
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) busy_cnt <= '0;
      else if (ins_go) busy_cnt <= INSTR_CNT;
      else if (dat_wr || dat_rd) busy_cnt <= DATA_CNT;
      else if (busy_flag) busy_cnt <= CNT_W'(busy_cnt - 1'b1);
   end

   // mode registers loaded by instructions
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_8bit_o <= RST_BUS8;
         ext_instr_bit_o <= 1'b0;
         line_shift_or_bank_o <= 1'b0;
         invert_all_o <= 1'b0;
         font_blink_en_o <= 1'b0;
         four_line_o <= 1'b0;
         line_shift_en_o <= RST_LINE_EN;
         rom_bank_sel_o <= RST_BANK;
         spi_frame_len_o <= RST_SPI_LEN;
         dir_up <= RST_DIR_UP;
      end else if (ins_go) begin
         if (op_fs) begin
            bus_8bit_o <= ev_byte[FS_IF_POS];
            ext_instr_bit_o <= ev_byte[FS_EXT_POS];
            if (!re) line_shift_or_bank_o <= ev_byte[FS_SEL_POS];
            if (!re) invert_all_o <= ev_byte[FS_REV_POS];
            if (re && !ev_byte[FS_REV_POS]) font_blink_en_o <= ev_byte[FS_SEL_POS];
         end
         if (op_shift && re && line_shift_or_bank_o) line_shift_en_o <= ev_byte[3:0];
         if (op_shift && re && !line_shift_or_bank_o) rom_bank_sel_o <= ev_byte[1:0];
         if (op_dd && re) spi_frame_len_o <= ev_byte[6:0];
         if (op_extfs) four_line_o <= ev_byte[0];
         if (op_entry) dir_up <= ev_byte[1];
      end
   end

   // plain shift: registered pulse out, cursor shift also moves the counter
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shift_pulse_o <= 1'b0;
         shift_display_o <= 1'b0;
         shift_right_o <= 1'b0;
      end else begin
         shift_pulse_o <= ins_go & op_shift & ~re;
         if (ins_go && op_shift && !re) begin
            shift_display_o <= ev_byte[3];
            shift_right_o <= ev_byte[2];
         end
      end
   end

   // address counter, target and transfer latch; a refetch follows each
   // address load and each read so the next read sees fresh data
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         addr_counter <= RST_AC;
         tgt <= TGT_CHAR;
         ram_transfer_latch <= 8'h00;
         fetch_q <= 1'b0;
      end else begin
         fetch_q <= op_addr | dat_rd;
         if (fetch_q) ram_transfer_latch <= cur_rd;
         else if (dat_wr) ram_transfer_latch <= ev_byte;
         if (ins_go && op_font && !re) begin
            tgt <= TGT_FONT;
            addr_counter <= {1'b0, ev_byte[5:0]};
         end else if (ins_go && op_font && re) begin
            tgt <= TGT_ICON;
            addr_counter <= {3'b000, ev_byte[3:0]};
         end else if (ins_go && op_dd && !re) begin
            tgt <= TGT_CHAR;
            addr_counter <= ev_byte[6:0];
         end else if (ins_go && op_shift && !re && !ev_byte[3]) begin
            addr_counter <= step_dd(addr_counter, ev_byte[2], four_line_o);
         end else if (dat_wr || dat_rd) begin
            addr_counter <= ac_step;
         end
      end
   end

   // commit on write; character cells keep the current bank above the data
   always_ff @(posedge mclk_i) begin
      if (dat_wr && tgt == TGT_CHAR && dd_wr_ok)
         char_code_ram[addr_counter] <= {rom_bank_sel_o, ev_byte};
      if (dat_wr && tgt == TGT_FONT) user_font_ram[addr_counter[5:0]] <= ev_byte;
      if (dat_wr && tgt == TGT_ICON) icon_ram[addr_counter[3:0]] <= ev_byte;
   end

   // display-side read port; only bank zero low codes point at the user font
   wire [CODE_W-1:0] disp_cell = char_code_ram[disp_addr_i];
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         disp_code_o <= '0;
         disp_user_o <= 1'b0;
      end else begin
         disp_code_o <= disp_cell;
         disp_user_o <= (disp_cell[9:8] == BANK_USER) && (disp_cell[7:4] == 4'h0);
      end
   end

   // read drive: status or latch only, the command latch has no path out
   wire rd_drive = bus_kind_select & e_p & rw_p;
   wire [7:0] rd_word = rs_p ? ram_transfer_latch : {busy_flag, addr_counter};
   wire [7:0] rd_bus = bus_8bit_o ? rd_word :
                       (nib_ph ? {rd_word[3:0], 4'h0} : {rd_word[7:4], 4'h0});
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         db_o <= 8'h00;
         db_oe_o <= 8'h00;
      end else begin
         db_o <= rd_drive ? rd_bus : 8'h00;
         db_oe_o <= rd_drive ? (bus_8bit_o ? 8'hff : 8'hf0) : 8'h00;
      end
   end

   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   localparam int INS_LO = 920;
   localparam int INS_HI = 926;
   // data busy age, counted because its window is too long for a delay range
   logic [CNT_W-1:0] dat_age;
   always_ff @(posedge mclk_i or negedge rstn_i)
      if (!rstn_i) dat_age <= '0;
      else if (dat_wr || dat_rd) dat_age <= CNT_W'(1);
      else dat_age <= (dat_age == '0 || dat_age == DATA_CNT) ? '0 : CNT_W'(dat_age + 1'b1);

   busy_hold_a: assert property (ins_go |=> busy_flag [*8])
      else $error("busy not raised after instruction");
   ins_time_a: assert property (ins_go |-> ##[INS_LO:INS_HI] !busy_flag)
      else $error("instruction busy time wrong");
   dat_time_a: assert property (dat_age == DATA_CNT |-> busy_flag ##1 !busy_flag)
      else $error("data busy time wrong");
   drop_busy_a: assert property (ev_valid && !ev_rs && !ev_rw && busy_flag
      |=> $stable(addr_counter) && $stable(ext_instr_bit_o))
      else $error("instruction taken while busy");
   status_rd_a: assert property (rd_drive && !rs_p && bus_8bit_o
      |=> db_o == {$past(busy_flag), $past(addr_counter)} && db_oe_o == 8'hff)
      else $error("status read wrong");
   fs_load_a: assert property (ins_go && op_fs
      |=> ext_instr_bit_o == $past(ev_byte[2]) && bus_8bit_o == $past(ev_byte[4]))
      else $error("function set not loaded");
   bank_sel_a: assert property (ins_go && op_shift && re && !line_shift_or_bank_o
      |=> rom_bank_sel_o == $past(ev_byte[1:0]))
      else $error("bank select not loaded");
   dd_addr_a: assert property (ins_go && op_dd && !re
      |=> addr_counter == $past(ev_byte[6:0]) && tgt == TGT_CHAR)
      else $error("character address not loaded");
   font_step_a: assert property (dat_wr && tgt == TGT_FONT |=> addr_counter[5:0] ==
      ($past(dir_up) ? 6'($past(addr_counter[5:0]) + 6'd1) : 6'($past(addr_counter[5:0]) - 6'd1)))
      else $error("font address step wrong");
   cell_wr_a: assert property (dat_wr && tgt == TGT_CHAR && dd_wr_ok |=>
      char_code_ram[$past(addr_counter)] == {$past(rom_bank_sel_o), $past(ev_byte)})
      else $error("character cell content wrong");
   refetch_a: assert property (dat_rd |=> fetch_q ##1 ram_transfer_latch == $past(cur_rd))
      else $error("latch not refetched");

   fs_seen_c: cover property (ins_go && op_fs && ev_byte[2]);
   wr_seen_c: cover property (dat_wr && tgt == TGT_CHAR);
   rd_seen_c: cover property (dat_rd ##[1:8] fetch_q);
   ser_seen_c: cover property (ser_done && !ev_rs);
endmodule // lhcd_host_if

// ### testbench/lhcd_host_model.sv
// host processor model driving the decoder pins in bus and serial form
`timescale 1ns/10ps
module lhcd_host_model #(
   parameter int HALF_OSC = 47
) (
   input wire logic mclk_i,
   input wire logic [7:0] db_o,
   input wire logic [7:0] db_oe_o,
   output logic bus_kind_o,
   output logic pick_o,
   output logic rw_o,
   output logic e_o,
   output logic [7:0] db_i_o
);
   logic nib4 = 1'b0;
   // pins idle in bus mode with the strobe low
   initial begin
      bus_kind_o = 1'b1;
      pick_o = 1'b0;
      rw_o = 1'b0;
      e_o = 1'b0;
      db_i_o = 8'h5a;
   end
   // pins set four clocks before the strobe and held six after it so the input sync settles
   task automatic strobe(input logic rs, input logic rd, input logic [7:0] d,
                         output logic [15:0] q);
      @(posedge mclk_i);
      pick_o <= rs;
      rw_o <= rd;
      db_i_o <= d;
      repeat (4) @(posedge mclk_i);
      e_o <= 1'b1;
      repeat (9) @(posedge mclk_i);
      q = {db_oe_o, db_o};
      e_o <= 1'b0;
      repeat (6) @(posedge mclk_i);
      db_i_o <= ~d;  // released lines must not keep the last value
   endtask
   // one byte, split high nibble first in narrow mode
   task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
                       output logic [15:0] q);
      logic [15:0] a;
      logic [15:0] b;
      if (nib4) begin
         strobe(rs, rd, {d[7:4], ~d[3:0]}, a);
         strobe(rs, rd, {d[3:0], ~d[7:4]}, b);
         q = {a[15:8], a[7:4], b[7:4]};
      end else begin
         strobe(rs, rd, d, q);
      end
   endtask
   // poll until idle, then leave half an oscillator period
   task automatic wait_ready(output logic ok);
      logic [15:0] q;
      ok = 1'b0;
      for (int n = 0; n < 200 && !ok; n++) begin
         xfer(1'b0, 1'b1, 8'h00, q);
         ok = (q[7] === 1'b0);
      end
      repeat (HALF_OSC) @(posedge mclk_i);
   endtask
   // change bus kind with the chip deselected and serial clock still
   task automatic set_kind(input logic k);
      @(posedge mclk_i);
      bus_kind_o <= k;
      db_i_o <= 8'h20;
      repeat (6) @(posedge mclk_i);
   endtask
   // serial frame: pick bit first, then data msb first
   task automatic ser(input logic rs, input logic [7:0] d);
      logic [8:0] f;
      f = {rs, d};
      for (int i = 8; i >= 0; i--) begin
         @(posedge mclk_i);
         db_i_o <= {f[i], 7'h00};
         repeat (5) @(posedge mclk_i);
         db_i_o <= {f[i], 7'h40};
         repeat (5) @(posedge mclk_i);
      end
      @(posedge mclk_i);
      db_i_o <= {~f[0], 7'h20};
      repeat (5) @(posedge mclk_i);
   endtask
endmodule // lhcd_host_model

// ### testbench/tb_lhcd_host_if.sv
// self-checking bench for the host command decoder
`timescale 1ns/10ps
module tb_lhcd_host_if;
   import lhcd_pkg::*;
   typedef struct {string nm; int sel; logic [15:0] exp;} lhcd_note_s;
   logic mclk_i = 1'b0;
   logic rstn_i, bks, rsel, rw, e, chk_req, four, ext, bus8, dcb, invert_all, user, spd, spr, pulse, blink;
   logic [7:0] dbi, dbo, dboe;
   logic [6:0] spi_len;
   logic [AC_W-1:0] daddr;
   logic [CODE_W-1:0] code;
   logic [3:0] lse;
   logic [1:0] bank;
   logic [15:0] rd_q;
   logic [7:0] pulses = 8'h00;
   int num_errors = 0;
   int checks = 0;
   int seed;
   lhcd_note_s notes[$];
   lhcd_note_s nt;

   always #20 mclk_i = ~mclk_i;

   lhcd_host_if lhcd_host_if_inst (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .bus_kind_select_i(bks), .register_pick_i(rsel),
      .rw_i(rw), .e_i(e), .db_i(dbi), .db_o(dbo), .db_oe_o(dboe), .disp_addr_i(daddr),
      .disp_code_o(code), .disp_user_o(user), .shift_pulse_o(pulse), .shift_display_o(spd),
      .shift_right_o(spr), .line_shift_en_o(lse), .rom_bank_sel_o(bank),
      .line_shift_or_bank_o(dcb), .invert_all_o(invert_all), .font_blink_en_o(blink),
      .four_line_o(four), .ext_instr_bit_o(ext), .bus_8bit_o(bus8), .spi_frame_len_o(spi_len));
   lhcd_host_model lhcd_host_model_inst (
      .mclk_i(mclk_i), .db_o(dbo), .db_oe_o(dboe), .bus_kind_o(bks), .pick_o(rsel),
      .rw_o(rw), .e_o(e), .db_i_o(dbi));

   // output group picked by a note
   function automatic logic [15:0] pick(input int s);
      case (s)
         0: pick = rd_q;
         1: pick = {14'h0, spd, spr};
         2: pick = {12'h0, lse};
         3: pick = {14'h0, bank};
         4: pick = {11'h0, four, ext, bus8, dcb, invert_all};
         5: pick = {15'h0, blink};
         6: pick = {9'h0, spi_len};
         7: pick = {5'h0, user, code};
         default: pick = {8'h0, pulses};
      endcase
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // oldest note is compared once the driver flags a result
   always @(posedge mclk_i) begin
      if (chk_req === 1'b1) begin
         nt = notes.pop_front();
         check(nt.nm, pick(nt.sel), nt.exp);
      end
      if (pulse === 1'b1) pulses <= pulses + 8'h01;
   end
   task automatic look(input string nm, input int sel, input logic [15:0] exp);
      notes.push_back('{nm, sel, exp});
      @(posedge mclk_i);
      chk_req <= 1'b1;
      @(posedge mclk_i);
      chk_req <= 1'b0;
   endtask
   task automatic ready();
      logic ok;
      lhcd_host_model_inst.wait_ready(ok);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("ERROR busy expected 0 seen 1");
         tally_and_finish();
      end
   endtask
   task automatic acc(input int rs, input int rd, input logic [7:0] d);
      lhcd_host_model_inst.xfer(1'(rs), 1'(rd), d, rd_q);
      ready();
   endtask
   task automatic stat(input logic [7:0] exp);
      lhcd_host_model_inst.xfer(1'b0, 1'b1, 8'h00, rd_q);
      look("status", 0, {lhcd_host_model_inst.nib4 ? 8'hf0 : 8'hff, exp});
   endtask
   // main sequence; each wait on the device is bounded inside ready
   initial begin
      rstn_i = 1'b0;
      chk_req = 1'b0;
      daddr = 7'h00;
      seed = 84658;
      repeat (6) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      look("modes", 4, 16'h0004);
      acc(0, 0, 8'h33);
      look("modes", 4, 16'h0007);
      for (int i = 0; i < 4; i++) begin
         acc(0, 0, 8'h10 | 8'(i * 4));
         look("shift", 1, 16'(i));
      end
      look("pulses", 8, 16'h0004);
      $display("test mode and shift done");
      acc(0, 0, 8'h36);
      acc(0, 0, 8'h36); // second one is decoded with the extension bit already set
      look("blink", 5, 16'h0001);
      acc(0, 0, 8'h1a);
      look("lines", 2, 16'h000a);
      acc(0, 0, 8'hda);
      look("frame", 6, 16'h005a);
      acc(0, 0, 8'h7f);
      stat(8'h0f);
      look("pulses", 8, 16'h0004);
      acc(0, 0, 8'h30);
      acc(0, 0, 8'h34);
      look("blink", 5, 16'h0000);
      for (int b = 0; b < 4; b++) begin
         acc(0, 0, 8'h10 | 8'(b));
         look("bank", 3, 16'(b));
      end
      $display("test extended set done");
      for (int k = 0; k < 5; k++) begin
         logic [1:0] bk;
         logic [7:0] d;
         logic [6:0] a;
         bk = 2'($random(seed));
         d = 8'($random(seed)) & 8'h1f;
         a = 7'({$random(seed)} % 40) | (k[0] ? 7'h40 : 7'h00);
         acc(0, 0, 8'h34);
         acc(0, 0, 8'h10 | 8'(bk));
         acc(0, 0, 8'h30);
         acc(0, 0, 8'h80 | 8'(a));
         acc(1, 0, d);
         daddr <= a;
         repeat (2) @(posedge mclk_i);
         look("cell", 7, {5'h0, bk == 2'h0 && d < 8'h10, bk, d});
      end
      acc(0, 0, 8'ha7);
      stat(8'h27);
      acc(1, 0, 8'ha5);
      stat(8'h40);
      acc(0, 0, 8'ha7);
      acc(1, 1, 8'h00);
      look("data", 0, 16'hffa5);
      acc(0, 0, 8'h34);
      acc(0, 0, 8'h09);
      acc(0, 0, 8'h30);
      look("modes", 4, 16'h0014);
      acc(0, 0, 8'h93);
      acc(1, 0, 8'h41);
      stat(8'h20);
      acc(0, 0, 8'h7f);
      stat(8'h3f);
      acc(1, 0, 8'h15);
      stat(8'h00);
      acc(0, 0, 8'h7f);
      acc(1, 1, 8'h00);
      look("font", 0, 16'hff15);
      $display("test ram access done");
      lhcd_host_model_inst.xfer(1'b0, 1'b0, 8'h90, rd_q);
      stat(8'h90);
      lhcd_host_model_inst.xfer(1'b0, 1'b0, 8'ha0, rd_q);
      ready();
      stat(8'h10);
      lhcd_host_model_inst.xfer(1'b0, 1'b0, 8'h20, rd_q);
      lhcd_host_model_inst.nib4 = 1'b1;
      ready();
      look("modes", 4, 16'h0010);
      acc(0, 0, 8'h85);
      stat(8'h05);
      lhcd_host_model_inst.xfer(1'b0, 1'b0, 8'h30, rd_q);
      lhcd_host_model_inst.nib4 = 1'b0;
      ready();
      lhcd_host_model_inst.set_kind(1'b0);
      lhcd_host_model_inst.ser(1'b0, 8'h91);
      lhcd_host_model_inst.set_kind(1'b1);
      ready();
      stat(8'h11);
      $display("test bus kinds done");
      tally_and_finish();
   end
endmodule // tb_lhcd_host_if
